/* File: verilog/kpcs_stat_counters.sv */
`timescale 1ns/1ns
`default_nettype none
module kpcs_stat_counters (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Incoming column, one per enabled cycle.
	input wire kpcs_stat_pkg::kpcs_column_t rx_column,
	// Rate compensation and pattern checker events.
	input wire logic tx_idle_deletions,
	input wire logic tx_idle_additions,
	input wire logic rx_idle_deletions,
	input wire logic rx_idle_additions,
	input wire logic tx_pattern_checker_locked,
	// Management read port.
	input wire kpcs_stat_pkg::kpcs_mgmt_req_t mgmt_req,
	output logic [15:0] mgmt_rd_data,
	output logic mgmt_rd_valid
);

	logic [15:0] cnt_reg [kpcs_stat_pkg::NUM_COUNTERS];
	logic [kpcs_stat_pkg::NUM_COUNTERS-1:0] evt;
	logic [kpcs_stat_pkg::NUM_COUNTERS-1:0] rd_hit;
	logic [15:0] cnt_sel;
	logic st_hit;
	logic [kpcs_stat_pkg::ST_FLAGS_W-1:0] flags_reg;
	logic [kpcs_stat_pkg::ST_FLAGS_W-1:0] flags_set;
	logic lock_reg;
	logic term2_pend_reg;
	logic term2_l3bad_reg;
	logic term3_pend_reg;
	logic next_ka;
	logic [3:0] is_k;
	logic [3:0] is_a;
	logic [3:0] is_t;
	logic [3:0] is_s;
	logic [3:0] bad_lane;
	logic bad_start;
	logic bad_term;
	logic [15:0] rd_data_reg;
	logic rd_valid_reg;
	logic [15:0] rd_data_next;

	assign mgmt_rd_data = rd_data_reg;
	assign mgmt_rd_valid = rd_valid_reg;

	// Per-lane decode of the incoming column.
	genvar ln;
	generate
		for (ln = 0; ln < 4; ln++) begin : g_lane
			logic [7:0] code;
			assign code = rx_column.data[8*ln +: 8];
			assign is_k[ln] = rx_column.ctl[ln] &&
				code == kpcs_stat_pkg::CODE_IDLE_K;
			assign is_a[ln] = rx_column.ctl[ln] &&
				code == kpcs_stat_pkg::CODE_ALIGN_A;
			assign is_t[ln] = rx_column.ctl[ln] &&
				code == kpcs_stat_pkg::CODE_TERM;
			assign is_s[ln] = rx_column.ctl[ln] &&
				code == kpcs_stat_pkg::CODE_START;
			assign bad_lane[ln] = rx_column.ctl[ln] && !(is_k[ln] ||
				is_a[ln] || is_t[ln] || is_s[ln] ||
				code == kpcs_stat_pkg::CODE_SKIP_R ||
				code == kpcs_stat_pkg::CODE_ERROR ||
				code == kpcs_stat_pkg::CODE_SEQ_Q);
		end
	endgenerate

	assign next_ka = (&is_k) || (&is_a);

	// A start belongs in lane 0 with data in the other three lanes.
	assign bad_start = (|is_s[3:1]) ||
		(is_s[0] && (|rx_column.ctl[3:1]));

	// After a terminate every later lane must carry an idle.
	always_comb begin
		logic seen;
		seen = 1'b0;
		bad_term = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (seen && !is_k[i]) begin
				bad_term = 1'b1;
			end
			if (is_t[i]) begin
				seen = 1'b1;
			end
		end
	end

	assign flags_set = {bad_start, bad_term, bad_lane};

	// The terminate column is judged once the column after it arrives.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			term2_pend_reg <= 1'b0;
			term2_l3bad_reg <= 1'b0;
			term3_pend_reg <= 1'b0;
		end else if (clk_en) begin
			term2_pend_reg <= is_t[2];
			term2_l3bad_reg <= !is_k[3];
			term3_pend_reg <= is_t[3];
		end
	end

	assign evt[kpcs_stat_pkg::CNT_LANE2_EOP] = term2_pend_reg &&
		(term2_l3bad_reg || !next_ka);
	assign evt[kpcs_stat_pkg::CNT_LANE3_EOP] = term3_pend_reg &&
		!next_ka;
	assign evt[kpcs_stat_pkg::CNT_TX_DEL] = tx_idle_deletions;
	assign evt[kpcs_stat_pkg::CNT_TX_INS] = tx_idle_additions;
	assign evt[kpcs_stat_pkg::CNT_RX_DEL] = rx_idle_deletions;
	assign evt[kpcs_stat_pkg::CNT_RX_INS] = rx_idle_additions;

	// Address decode of the counter block and the status register.
	assign cnt_sel = mgmt_req.addr -
		kpcs_stat_pkg::LANE2_PACKET_END_ERROR_COUNT_OFF;
	assign st_hit = mgmt_req.rd &&
		mgmt_req.addr == kpcs_stat_pkg::PCS_ERROR_STATUS_OFF;

	// A read that meets an event leaves one count behind, so no event is lost.
	genvar g;
	generate
		for (g = 0; g < kpcs_stat_pkg::NUM_COUNTERS; g++) begin : g_cnt
			assign rd_hit[g] = mgmt_req.rd && cnt_sel == 16'(g);
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_reg[g] <= kpcs_stat_pkg::CNT_RESET;
				end else if (clk_en) begin
					if (rd_hit[g]) begin
						cnt_reg[g] <= evt[g] ? kpcs_stat_pkg::CNT_ONE :
							kpcs_stat_pkg::CNT_ZERO;
					end else if (evt[g] &&
						cnt_reg[g] != kpcs_stat_pkg::CNT_MAX) begin
						cnt_reg[g] <= cnt_reg[g] + kpcs_stat_pkg::CNT_ONE;
					end
				end
			end
		end
	endgenerate

	// Status flags latch high; a read clears them but a new event wins.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_reg <= kpcs_stat_pkg::ST_FLAGS_RESET;
		end else if (clk_en) begin
			flags_reg <= (st_hit ? kpcs_stat_pkg::ST_FLAGS_RESET : flags_reg) |
				flags_set;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_reg <= 1'b0;
		end else if (clk_en) begin
			lock_reg <= tx_pattern_checker_locked;
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		rd_data_next = kpcs_stat_pkg::CNT_ZERO;
		if (st_hit) begin
			rd_data_next = kpcs_stat_pkg::STATUS_RESET;
			rd_data_next[kpcs_stat_pkg::ST_LOCK_BIT] = lock_reg;
			rd_data_next[kpcs_stat_pkg::ST_FLAGS_W-1:0] = flags_reg;
		end else if (cnt_sel < kpcs_stat_pkg::NUM_COUNTERS_W) begin
			rd_data_next = cnt_reg[cnt_sel[2:0]];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_reg <= kpcs_stat_pkg::CNT_ZERO;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= mgmt_req.rd;
			if (mgmt_req.rd) begin
				rd_data_reg <= rd_data_next;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	lane2_count_a: assert property (clk_en && term2_pend_reg &&
		term2_l3bad_reg && !rd_hit[0] && cnt_reg[0] != 16'hffff
		|=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
		else $error("Lane 2 end error not counted.");

	lane3_count_a: assert property (clk_en && term3_pend_reg &&
		!next_ka && !rd_hit[1] && cnt_reg[1] != 16'hffff
		|=> cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001)
		else $error("Lane 3 end error not counted.");

	read_clear_a: assert property (clk_en && rd_hit[2] && !evt[2]
		|=> cnt_reg[2] == 16'h0000 && rd_valid_reg &&
		rd_data_reg == $past(cnt_reg[2]))
		else $error("Counter read did not return and clear.");

	tx_drop_a: assert property (clk_en && evt[2] && !rd_hit[2] &&
		cnt_reg[2] != 16'hffff |=> cnt_reg[2] == $past(cnt_reg[2]) + 16'h0001)
		else $error("Transmit deletion not counted.");

	tx_insert_a: assert property (clk_en && evt[3] && !rd_hit[3] &&
		cnt_reg[3] != 16'hffff |=> cnt_reg[3] == $past(cnt_reg[3]) + 16'h0001)
		else $error("Transmit addition not counted.");

	rx_drop_a: assert property (clk_en && evt[4] && !rd_hit[4] &&
		cnt_reg[4] != 16'hffff |=> cnt_reg[4] == $past(cnt_reg[4]) + 16'h0001)
		else $error("Receive deletion not counted.");

	rx_insert_a: assert property (clk_en && evt[5] && !rd_hit[5] &&
		cnt_reg[5] != 16'hffff |=> cnt_reg[5] == $past(cnt_reg[5]) + 16'h0001)
		else $error("Receive addition not counted.");

	lock_bit_a: assert property (clk_en ##1 clk_en && st_hit
		|=> rd_data_reg[15] == $past(tx_pattern_checker_locked, 2))
		else $error("Lock bit does not follow the checker.");

	start_flag_a: assert property (clk_en && bad_start
		|=> flags_reg[5])
		else $error("Invalid start column not latched.");

	term_flag_a: assert property (clk_en && bad_term
		|=> flags_reg[4])
		else $error("Invalid terminate column not latched.");

	lane_flag_a: assert property (clk_en && !st_hit && |flags_reg[3:0]
		|=> (flags_reg[3:0] & $past(flags_reg[3:0])) == $past(flags_reg[3:0]))
		else $error("Lane flag dropped without a read.");

	saturate_a: assert property (clk_en && cnt_reg[2] == 16'hffff &&
		evt[2] && !rd_hit[2] |=> cnt_reg[2] == 16'hffff)
		else $error("Counter wrapped past its maximum.");

	// Packet-end checks look one column back, through the pending flags.
	lane2_next_a: assert property (clk_en && term2_pend_reg &&
		!next_ka && !rd_hit[0] && cnt_reg[0] != 16'hffff
		|=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
		else $error("Lane 2 end before a bad column not counted.");

	lane2_hold_a: assert property (clk_en && term2_pend_reg &&
		!term2_l3bad_reg && next_ka && !rd_hit[0]
		|=> cnt_reg[0] == $past(cnt_reg[0]))
		else $error("Clean lane 2 packet end was counted.");

	lane3_hold_a: assert property (clk_en && term3_pend_reg &&
		next_ka && !rd_hit[1]
		|=> cnt_reg[1] == $past(cnt_reg[1]))
		else $error("Clean lane 3 packet end was counted.");

	lane_read_a: assert property (clk_en && rd_hit[0] && !evt[0]
		|=> cnt_reg[0] == 16'h0000 &&
		rd_data_reg == $past(cnt_reg[0]))
		else $error("Lane 2 counter read did not return and clear.");

	read_event_a: assert property (clk_en && rd_hit[2] && evt[2]
		|=> cnt_reg[2] == 16'h0001)
		else $error("Event during a read was lost.");

	// The read port answers every strobe taken while the enable is high, mapped or not, one cycle later.
	read_valid_a: assert property (clk_en
		|=> rd_valid_reg == $past(mgmt_req.rd))
		else $error("Read valid does not follow the strobe.");

	data_hold_a: assert property (clk_en && !mgmt_req.rd
		|=> rd_data_reg == $past(rd_data_reg))
		else $error("Read data changed without a read.");

	// The enable gates every register, so a frozen cycle must change nothing.
	freeze_a: assert property (!clk_en
		|=> cnt_reg[2] == $past(cnt_reg[2]) &&
		flags_reg == $past(flags_reg) &&
		rd_valid_reg == $past(rd_valid_reg))
		else $error("State moved while the enable was low.");

	lane_set_a: assert property (clk_en && |bad_lane
		|=> (flags_reg[3:0] & $past(bad_lane)) == $past(bad_lane))
		else $error("Invalid lane character not latched.");

	status_clear_a: assert property (clk_en && st_hit &&
		flags_set == kpcs_stat_pkg::ST_FLAGS_RESET
		|=> flags_reg == kpcs_stat_pkg::ST_FLAGS_RESET &&
		rd_data_reg[5:0] == $past(flags_reg))
		else $error("Status read did not return and clear flags.");

endmodule
`default_nettype wire

/* File: verilog/kpcs_stat_pkg.sv */
`default_nettype none
package kpcs_stat_pkg;

	// Management register offsets, device address 1.
	localparam logic [15:0] LANE2_PACKET_END_ERROR_COUNT_OFF = 16'h8012;
	localparam logic [15:0] LANE3_PACKET_END_ERROR_COUNT_OFF = 16'h8013;
	localparam logic [15:0] TX_IDLE_DROP_COUNT_OFF = 16'h8014;
	localparam logic [15:0] TX_IDLE_INSERT_COUNT_OFF = 16'h8015;
	localparam logic [15:0] RX_IDLE_DROP_COUNT_OFF = 16'h8016;
	localparam logic [15:0] RX_IDLE_INSERT_COUNT_OFF = 16'h8017;
	localparam logic [15:0] PCS_ERROR_STATUS_OFF = 16'h8018;
	localparam logic [15:0] DEV_ADDR = 16'h0001;

	// Counter block layout.
	localparam int NUM_COUNTERS = 6;
	localparam int CNT_WIDTH = 16;
	localparam logic [15:0] CNT_RESET = 16'hfffd;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] NUM_COUNTERS_W = 16'h0006;

	// Counter indices within the block.
	localparam int CNT_LANE2_EOP = 0;
	localparam int CNT_LANE3_EOP = 1;
	localparam int CNT_TX_DEL = 2;
	localparam int CNT_TX_INS = 3;
	localparam int CNT_RX_DEL = 4;
	localparam int CNT_RX_INS = 5;

	// Status register field positions.
	localparam int ST_LOCK_BIT = 15;
	localparam int ST_START_COL_BIT = 5;
	localparam int ST_TERM_COL_BIT = 4;
	localparam int ST_FLAGS_W = 6;
	localparam logic [5:0] ST_FLAGS_RESET = 6'h00;

	// Lane code groups, meaningful when the lane's control bit is set.
	localparam logic [7:0] CODE_IDLE_K = 8'hbc;
	localparam logic [7:0] CODE_ALIGN_A = 8'h7c;
	localparam logic [7:0] CODE_SKIP_R = 8'h1c;
	localparam logic [7:0] CODE_START = 8'hfb;
	localparam logic [7:0] CODE_TERM = 8'hfd;
	localparam logic [7:0] CODE_ERROR = 8'hfe;
	localparam logic [7:0] CODE_SEQ_Q = 8'h9c;

	typedef struct packed {
		logic [3:0] ctl;
		logic [31:0] data;
	} kpcs_column_t;

	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} kpcs_mgmt_req_t;

endpackage
`default_nettype wire

/* File: tb/kpcs_mac_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Stands in for the MAC feeding columns, idle events and pattern lock.
// Everything moves 1 ns after the rising edge, so the design never
// samples a value in the middle of a change.
module kpcs_mac_model (
	// Clock.
	input wire logic core_clk,
	// Column stream, idle events and lock level.
	output var kpcs_stat_pkg::kpcs_column_t rx_column,
	output var logic [3:0] idle_events,
	output var logic locked
);
	initial begin
		rx_column = {4'hf, 32'hbcbc_bcbc};
		idle_events = 4'h0;
		locked = 1'b0;
	end
	// Each call holds its column until the next call, one cycle when calls run back to back.
	task automatic send(input logic [3:0] ctl, input logic [31:0] data);
		@(posedge core_clk);
		#1 rx_column = {ctl, data};
	endtask
	// Back-to-back events: the line stays high for n cycles.
	task automatic pulse(input int idx, input int n);
		@(posedge core_clk);
		#1 idle_events[idx] = 1'b1;
		repeat (n) @(posedge core_clk);
		#1 idle_events[idx] = 1'b0;
	endtask
	task automatic set_lock(input logic v);
		@(posedge core_clk);
		#1 locked = v;
	endtask
endmodule
`default_nettype wire

/* File: tb/kr_pcs_error_stat_counters_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module kr_pcs_error_stat_counters_tb;
	logic core_clk;
	logic sys_rst;
	logic clk_en;
	kpcs_stat_pkg::kpcs_column_t rx_column;
	logic [3:0] ev;
	logic locked;
	kpcs_stat_pkg::kpcs_mgmt_req_t mgmt_req;
	logic [15:0] mgmt_rd_data;
	logic mgmt_rd_valid;
	int fail_count = 0;
	int comparisons = 0;
	kpcs_mac_model mac (.core_clk(core_clk), .rx_column(rx_column),
		.idle_events(ev), .locked(locked));
	kpcs_stat_counters dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .rx_column(rx_column), .tx_idle_deletions(ev[0]),
		.tx_idle_additions(ev[1]), .rx_idle_deletions(ev[2]),
		.rx_idle_additions(ev[3]), .tx_pattern_checker_locked(locked),
		.mgmt_req(mgmt_req), .mgmt_rd_data(mgmt_rd_data),
		.mgmt_rd_valid(mgmt_rd_valid));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One read strobe; the answer is looked at in its single valid cycle.
	task automatic rdc(input logic [15:0] addr, input logic [15:0] exp);
		@(posedge core_clk);
		#1 mgmt_req = {1'b1, addr};
		@(posedge core_clk);
		#1 mgmt_req = {1'b0, addr};
		check("rd_valid", {15'h0000, mgmt_rd_valid}, 16'h0001);
		check($sformatf("reg %h", addr), mgmt_rd_data, exp);
	endtask
	task automatic defaults_and_clear();
		mac.pulse(0, 3);
		for (int i = 0; i < 6; i++) begin
			rdc(16'h8012 + 16'(i), (i == 2) ? 16'hffff : 16'hfffd);
		end
		rdc(16'h8018, 16'h0000);
		rdc(16'h8019, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rdc(16'h8012 + 16'(i), 16'h0000);
		end
	endtask
	task automatic events_count();
		for (int i = 0; i < 4; i++) begin
			mac.pulse(i, i + 1);
		end
		for (int i = 0; i < 4; i++) begin
			rdc(16'h8014 + 16'(i), 16'(i + 1));
		end
	endtask
	task automatic packet_end();
		mac.send(4'hc, 32'hbcfd_0000);
		mac.send(4'hf, 32'hbcbc_bcbc);
		mac.send(4'hc, 32'hbcfd_0000);
		mac.send(4'h0, 32'h0000_0000);
		mac.send(4'h4, 32'h00fd_0000);
		mac.send(4'hf, 32'hbcbc_bcbc);
		mac.send(4'h8, 32'hfd00_0000);
		mac.send(4'hf, 32'h7c7c_7c7c);
		mac.send(4'h8, 32'hfd00_0000);
		mac.send(4'h0, 32'h0000_0000);
		mac.send(4'hf, 32'hbcbc_bcbc);
		rdc(16'h8012, 16'h0002);
		rdc(16'h8013, 16'h0001);
		rdc(16'h8018, 16'h0010);
	endtask
	task automatic status_flags();
		mac.send(4'h2, 32'h0000_5500);
		mac.send(4'h4, 32'h00fb_0000);
		mac.send(4'h1, 32'h0000_00fd);
		mac.send(4'hf, 32'hbcbc_bcbc);
		rdc(16'h8018, 16'h0032);
		rdc(16'h8018, 16'h0000);
		mac.set_lock(1'b1);
		rdc(16'h8018, 16'h8000);
		rdc(16'h8018, 16'h8000);
		mac.set_lock(1'b0);
		rdc(16'h8018, 16'h0000);
	endtask
	// A low enable must swallow events and strobes alike.
	task automatic enable_freeze();
		@(posedge core_clk);
		#1 clk_en = 1'b0;
		mac.pulse(0, 2);
		@(posedge core_clk);
		#1 mgmt_req = {1'b1, 16'h8014};
		@(posedge core_clk);
		#1 mgmt_req = {1'b0, 16'h8014};
		clk_en = 1'b1;
		check("rd_valid frozen", {15'h0000, mgmt_rd_valid}, 16'h0000);
		fork
			mac.pulse(0, 1);
			rdc(16'h8014, 16'h0000);
		join
		rdc(16'h8014, 16'h0001);
	endtask
	// A second reset mid-run restores defaults and drops latched flags.
	task automatic reset_again();
		mac.send(4'h1, 32'h0000_0055);
		mac.send(4'hf, 32'hbcbc_bcbc);
		@(posedge core_clk);
		#1 sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		rdc(16'h8014, 16'hfffd);
		rdc(16'h8018, 16'h0000);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		mgmt_req = {1'b0, 16'h0000};
		repeat (10) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		defaults_and_clear();
		events_count();
		packet_end();
		status_flags();
		enable_freeze();
		reset_again();
		conclude();
	end
	// The whole run needs about 120 cycles; this is ample headroom.
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
